// >>> wtc_pkg.sv
// Constants and register map for the wait timer and threshold compare block
`default_nettype none
package wtc_pkg;
   // Timing
   localparam int CLK_PERIOD_NS = 4;              // 250 MHz clock
   localparam int TICK_TIME_NS  = 2810000;        // 2.81 ms wait tick
   localparam int TICK_CYC      = TICK_TIME_NS / CLK_PERIOD_NS;
   localparam int TICK_W        = 20;             // Tick counter width
   localparam logic [3:0] LONG_LAST = 4'hb;       // 12 ticks per long unit
   // Persistence decoding
   localparam logic [3:0] ALS_PERS_BASE  = 4'h3;  // Direct up to this
   localparam logic [5:0] ALS_PERS_SCALE = 6'h05; // Step above it
   localparam logic [5:0] CNT_MAX        = 6'h3f; // Counter saturation
   // Bus
   localparam int ADDR_W = 10;                    // Byte address width
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   // Register indices, byte address is four times the index
   localparam logic [7:0] IDX_ENABLE  = 8'h80;
   localparam logic [7:0] IDX_WAIT    = 8'h83;
   localparam logic [7:0] IDX_ALO_LO  = 8'h84;
   localparam logic [7:0] IDX_ALO_HI  = 8'h85;
   localparam logic [7:0] IDX_AHI_LO  = 8'h86;
   localparam logic [7:0] IDX_AHI_HI  = 8'h87;
   localparam logic [7:0] IDX_PLO     = 8'h88;
   localparam logic [7:0] IDX_PHI     = 8'h8a;
   localparam logic [7:0] IDX_PERS    = 8'h8c;
   localparam logic [7:0] IDX_CFG     = 8'h8d;
   localparam logic [7:0] IDX_INTEN   = 8'h90;
   localparam logic [7:0] IDX_STATUS  = 8'h93;
   // Field positions
   localparam int WEN_BIT   = 3;                  // Enable register
   localparam int WLONG_BIT = 2;                  // Config register
   localparam int AINT_BIT  = 0;                  // Status and enable
   localparam int PINT_BIT  = 1;
   localparam int WDONE_BIT = 2;
   localparam int STAT_W    = 3;
   // Reset values
   localparam logic [7:0] ENABLE_RST = 8'h00;
   localparam logic [7:0] WAIT_RST   = 8'h00;
   localparam logic [7:0] THR_RST    = 8'h00;
   localparam logic [7:0] PERS_RST   = 8'h00;
   localparam logic [7:0] CFG_RST    = 8'h80;
endpackage : wtc_pkg
`default_nettype wire

// >>> wtc_pers.sv
// Persistence filter for one measurement channel
`timescale 1ns/1ps
`default_nettype none
module wtc_pers
   import wtc_pkg::*;
(
   input  wire logic       clock,        // System clock
   input  wire logic       rst_b,        // Async reset, active low
   input  wire logic       meas_done,    // Measurement finished pulse
   input  wire logic       out_of_range, // Result outside thresholds
   input  wire logic [3:0] pers_set,     // Persistence setting
   input  wire logic       scale_als,    // Use ambient decoding
   output logic            fire          // Flag set pulse
);
   logic [5:0] cnt_r;     // Consecutive out of range count
   logic [5:0] cnt_inc;   // Count including this result
   logic [5:0] need;      // Results required
   logic       fire_nxt;  // Next pulse

   // Required count per channel decoding
   assign need = (scale_als && pers_set > ALS_PERS_BASE) ?
                 6'(ALS_PERS_SCALE * 6'(pers_set - ALS_PERS_BASE)) :
                 {2'b00, pers_set};
   assign cnt_inc  = (cnt_r == CNT_MAX) ? CNT_MAX : cnt_r + 6'h01;
   // Zero fires every cycle, else on enough consecutive results
   assign fire_nxt = meas_done &&
                     (pers_set == 4'h0 || (out_of_range && cnt_inc >= need));

   // Count once per finished cycle
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         cnt_r <= 6'h00;
         fire  <= 1'b0;
      end else begin
         fire <= fire_nxt;
         if (meas_done) begin
            cnt_r <= out_of_range ? cnt_inc : 6'h00;
         end
      end
   end
endmodule : wtc_pers
`default_nettype wire

// >>> wtc_top.sv
// Wait timer, thresholds, interrupt flags and AXI4-Lite register slave
`timescale 1ns/1ps
`default_nettype none
module wtc_top
   import wtc_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYC   // Clocks per wait tick
)(
   input  wire logic              clock,       // 250 MHz clock
   input  wire logic              rst_b,       // Async reset, active low
   input  wire logic [ADDR_W-1:0] awaddr,      // Write address
   input  wire logic              awvalid,     // Write address valid
   output logic                   awready,     // Write address ready
   input  wire logic [31:0]       wdata,       // Write data
   input  wire logic [3:0]        wstrb,       // Write strobes
   input  wire logic              wvalid,      // Write data valid
   output logic                   wready,      // Write data ready
   output logic [1:0]             bresp,       // Write response
   output logic                   bvalid,      // Write response valid
   input  wire logic              bready,      // Write response ready
   input  wire logic [ADDR_W-1:0] araddr,      // Read address
   input  wire logic              arvalid,     // Read address valid
   output logic                   arready,     // Read address ready
   output logic [31:0]            rdata,       // Read data
   output logic [1:0]             rresp,       // Read response
   output logic                   rvalid,      // Read data valid
   input  wire logic              rready,      // Read data ready
   input  wire logic              als_done,    // Ambient cycle done pulse
   input  wire logic [15:0]       als_clear,   // Clear channel result
   input  wire logic              prox_done,   // Proximity cycle done pulse
   input  wire logic [7:0]        prox_value,  // Proximity result
   input  wire logic              wait_start,  // Start wait interval pulse
   output logic                   wait_busy,   // Wait interval running
   output logic                   wait_done,   // Wait interval end pulse
   output logic                   irq          // Interrupt, active high
);
   // Register storage
   logic [7:0]        enable_r;     // Enable register
   logic [7:0]        wait_r;       // Wait count
   logic [15:0]       als_lo_r;     // Ambient low threshold
   logic [15:0]       als_hi_r;     // Ambient high threshold

   logic [7:0]        byte_latch_r; // Held low byte
   logic [7:0]        prox_lo_r;    // Proximity low threshold
   logic [7:0]        prox_hi_r;    // Proximity high threshold

   logic [7:0]        pers_r;       // Persistence settings
   logic [7:0]        cfg_r;        // Config, long wait bit
   logic [STAT_W-1:0] inten_r;      // Interrupt enables

   logic [STAT_W-1:0] stat_r;       // Sticky flags
   logic [STAT_W-1:0] stat_nxt;     // Next flags

   // Bus state
   logic              aw_full_r;    // Address held
   logic              w_full_r;     // Data held
   logic [7:0]        wa_idx_r;     // Held write index
   logic [31:0]       wd_r;         // Held write data

   logic              ws_r;         // Low lane strobe held
   logic              aw_take;      // Address accepted
   logic              w_take;       // Data accepted
   logic              do_wr;        // Commit write this cycle
   logic              aw_full_nxt;  // Next address held
   logic              w_full_nxt;   // Next data held

   logic              bvalid_nxt;   // Next response valid
   logic              ar_take;      // Read accepted
   logic              rvalid_nxt;   // Next read valid

   logic [7:0]        ra_idx;       // Read index
   logic [7:0]        rd_byte;      // Decoded read value

   logic              rd_hit;       // Read address mapped
   logic              wr_hit;       // Write address mapped

   // Write strobes per register
   logic              wr_en;        // Committed write with lane 0
   logic              wr_alo_lo;    // Ambient low, low byte
   logic              wr_alo_hi;    // Ambient low, high byte
   logic              wr_ahi_lo;    // Ambient high, low byte
   logic              wr_ahi_hi;    // Ambient high, high byte

   logic              wr_status;    // Status clear write

   logic [STAT_W-1:0] stat_clr;     // Bits to clear
   logic [STAT_W-1:0] stat_set;     // Bits to set

   // Measurement side
   logic              als_oor;      // Clear outside range
   logic              prox_oor;     // Proximity outside range

   logic              als_fire;     // Ambient flag set
   logic              prox_fire;    // Proximity flag set

   // Wait timer
   logic [TICK_W-1:0] tick_cnt_r;   // Base tick divider
   logic [3:0]        long_cnt_r;   // Long wait prescaler

   logic [7:0]        wcnt_r;       // Wait down counter
   logic              tick_en;      // Base tick enable

   logic              unit_en;      // Wait unit enable
   logic              start_ok;     // Accepted start

   // Handshake decode
   assign aw_take     = awvalid && awready;
   assign w_take      = wvalid && wready;
   assign do_wr       = aw_full_r && w_full_r && !bvalid;
   assign aw_full_nxt = aw_take || (aw_full_r && !do_wr);
   assign w_full_nxt  = w_take || (w_full_r && !do_wr);
   assign bvalid_nxt  = do_wr || (bvalid && !bready);

   assign ar_take     = arvalid && arready;
   assign rvalid_nxt  = ar_take || (rvalid && !rready);
   assign ra_idx      = araddr[9:2];

   // Write address decode
   assign wr_hit    = (wa_idx_r == IDX_ENABLE) || (wa_idx_r == IDX_WAIT) ||
                      (wa_idx_r == IDX_ALO_LO) || (wa_idx_r == IDX_ALO_HI) ||
                      (wa_idx_r == IDX_AHI_LO) || (wa_idx_r == IDX_AHI_HI) ||
                      (wa_idx_r == IDX_PLO)    || (wa_idx_r == IDX_PHI) ||
                      (wa_idx_r == IDX_PERS)   || (wa_idx_r == IDX_CFG) ||
                      (wa_idx_r == IDX_INTEN)  || (wa_idx_r == IDX_STATUS);
   assign wr_en     = do_wr && ws_r;

   assign wr_alo_lo = wr_en && (wa_idx_r == IDX_ALO_LO);
   assign wr_alo_hi = wr_en && (wa_idx_r == IDX_ALO_HI);
   assign wr_ahi_lo = wr_en && (wa_idx_r == IDX_AHI_LO);
   assign wr_ahi_hi = wr_en && (wa_idx_r == IDX_AHI_HI);
   assign wr_status = wr_en && (wa_idx_r == IDX_STATUS);

   // Read decode, low bytes show the applied threshold
   assign rd_hit = (ra_idx == IDX_ENABLE) || (ra_idx == IDX_WAIT) ||
                   (ra_idx == IDX_ALO_LO) || (ra_idx == IDX_ALO_HI) ||
                   (ra_idx == IDX_AHI_LO) || (ra_idx == IDX_AHI_HI) ||
                   (ra_idx == IDX_PLO)    || (ra_idx == IDX_PHI) ||
                   (ra_idx == IDX_PERS)   || (ra_idx == IDX_CFG) ||
                   (ra_idx == IDX_INTEN)  || (ra_idx == IDX_STATUS);
   assign rd_byte =
      (ra_idx == IDX_ENABLE) ? enable_r :
      (ra_idx == IDX_WAIT)   ? wait_r :
      (ra_idx == IDX_ALO_LO) ? als_lo_r[7:0] :
      (ra_idx == IDX_ALO_HI) ? als_lo_r[15:8] :
      (ra_idx == IDX_AHI_LO) ? als_hi_r[7:0] :
      (ra_idx == IDX_AHI_HI) ? als_hi_r[15:8] :
      (ra_idx == IDX_PLO)    ? prox_lo_r :
      (ra_idx == IDX_PHI)    ? prox_hi_r :
      (ra_idx == IDX_PERS)   ? pers_r :
      (ra_idx == IDX_CFG)    ? cfg_r :
      (ra_idx == IDX_INTEN)  ? {{(8-STAT_W){1'b0}}, inten_r} :
      (ra_idx == IDX_STATUS) ? {{(8-STAT_W){1'b0}}, stat_r} : 8'h00;

   // Threshold compare on finished cycles
   assign als_oor  = (als_clear < als_lo_r) ||
                     (als_clear > als_hi_r);
   assign prox_oor = (prox_value < prox_lo_r) ||
                     (prox_value > prox_hi_r);

   // Status flags, set wins over write-one clear
   assign stat_clr = wr_status ? wd_r[STAT_W-1:0] : {STAT_W{1'b0}};
   assign stat_set = {wait_done, prox_fire, als_fire};

   assign stat_nxt = (stat_r & ~stat_clr) | stat_set;

   // Wait tick enables
   assign tick_en  = (tick_cnt_r == TICK_W'(TICK_CYCLES - 1));
   assign unit_en  = cfg_r[WLONG_BIT] ?
                     (tick_en && long_cnt_r == LONG_LAST) :
                     tick_en;

   assign start_ok = wait_start && enable_r[WEN_BIT] && !wait_busy;

   // Ambient persistence filter
   wtc_pers u_als_pers (
      .clock        (clock),
      .rst_b        (rst_b),
      .meas_done    (als_done),
      .out_of_range (als_oor),
      .pers_set     (pers_r[3:0]),
      .scale_als    (1'b1),
      .fire         (als_fire)
   );

   // Proximity persistence filter
   wtc_pers u_prox_pers (
      .clock        (clock),
      .rst_b        (rst_b),
      .meas_done    (prox_done),
      .out_of_range (prox_oor),
      .pers_set     (pers_r[7:4]),
      .scale_als    (1'b0),
      .fire         (prox_fire)
   );

   // Write channel holding registers
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         aw_full_r <= 1'b0;
         w_full_r  <= 1'b0;
         awready   <= 1'b1;
         wready    <= 1'b1;
         bvalid    <= 1'b0;
         bresp     <= RESP_OKAY;
      end else begin
         aw_full_r <= aw_full_nxt;
         w_full_r  <= w_full_nxt;
         awready   <= !aw_full_nxt && !bvalid_nxt;
         wready    <= !w_full_nxt && !bvalid_nxt;
         bvalid    <= bvalid_nxt;
         if (do_wr) begin
            bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   // Captured write address and data
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         wa_idx_r <= 8'h00;
         wd_r     <= 32'h0000_0000;
         ws_r     <= 1'b0;
      end else begin
         if (aw_take) begin
            wa_idx_r <= awaddr[9:2];
         end
         if (w_take) begin
            wd_r <= wdata;
            ws_r <= wstrb[0];
         end
      end
   end

   // Read channel
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
         rdata   <= 32'h0000_0000;
         rresp   <= RESP_OKAY;
      end else begin
         arready <= !rvalid_nxt;
         rvalid  <= rvalid_nxt;
         if (ar_take) begin
            rdata <= {24'h00_0000, rd_byte};
            rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   // Plain control registers
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         enable_r  <= ENABLE_RST;
         wait_r    <= WAIT_RST;
         prox_lo_r <= THR_RST;
         prox_hi_r <= THR_RST;
         pers_r    <= PERS_RST;
         cfg_r     <= CFG_RST;
         inten_r   <= {STAT_W{1'b0}};
      end else if (wr_en) begin
         case (wa_idx_r)
            IDX_ENABLE: enable_r  <= wd_r[7:0];
            IDX_WAIT:   wait_r    <= wd_r[7:0];
            IDX_PLO:    prox_lo_r <= wd_r[7:0];
            IDX_PHI:    prox_hi_r <= wd_r[7:0];
            IDX_PERS:   pers_r    <= wd_r[7:0];
            IDX_CFG:    cfg_r     <= wd_r[7:0];
            IDX_INTEN:  inten_r   <= wd_r[STAT_W-1:0];
            default:    enable_r  <= enable_r;             // Others elsewhere
         endcase
      end
   end

   // Coherent ambient thresholds through one shared byte latch
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         byte_latch_r <= THR_RST;
         als_lo_r     <= {THR_RST, THR_RST};
         als_hi_r     <= {THR_RST, THR_RST};
      end else begin
         if (wr_alo_lo || wr_ahi_lo) begin
            byte_latch_r <= wd_r[7:0];
         end
         if (wr_alo_hi) begin
            als_lo_r <= {wd_r[7:0], byte_latch_r};
         end
         if (wr_ahi_hi) begin
            als_hi_r <= {wd_r[7:0], byte_latch_r};
         end
      end
   end

   // Sticky flags and interrupt output
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         stat_r <= {STAT_W{1'b0}};
         irq    <= 1'b0;
      end else begin
         stat_r <= stat_nxt;
         irq    <= |(stat_r & inten_r);
      end
   end

   // Base tick divider and long prescaler, restarted by a start
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         tick_cnt_r <= '0;
         long_cnt_r <= 4'h0;
      end else if (start_ok) begin
         tick_cnt_r <= '0;
         long_cnt_r <= 4'h0;
      end else if (tick_en) begin
         tick_cnt_r <= '0;
         long_cnt_r <= (long_cnt_r == LONG_LAST) ? 4'h0 :
                       long_cnt_r + 4'h1;
      end else begin
         tick_cnt_r <= tick_cnt_r + TICK_W'(1);
      end
   end

   // Wait down counter, N gives N+1 units
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         wcnt_r    <= 8'h00;
         wait_busy <= 1'b0;
         wait_done <= 1'b0;
      end else begin
         wait_done <= 1'b0;
         if (start_ok) begin
            wcnt_r    <= wait_r;
            wait_busy <= 1'b1;
         end else if (wait_busy && unit_en) begin
            if (wcnt_r == 8'h00) begin
               wait_busy <= 1'b0;
               wait_done <= 1'b1;
            end else begin
               wcnt_r <= wcnt_r - 8'h01;
            end
         end
      end
   end
endmodule : wtc_top
`default_nettype wire

// >>> wtc_host.sv
// Host model driving the register bus as an AXI4-Lite master
`timescale 1ns/1ps
`default_nettype none
module wtc_host
   import wtc_pkg::*;
(
   input  wire logic         clock,   // Clock
   output logic [ADDR_W-1:0] awaddr,  // AW address
   output logic              awvalid, // AW valid
   input  wire logic         awready, // AW ready
   output logic [31:0]       wdata,   // W data
   output logic [3:0]        wstrb,   // W strobes
   output logic              wvalid,  // W valid
   input  wire logic         wready,  // W ready
   input  wire logic [1:0]   bresp,   // B response
   input  wire logic         bvalid,  // B valid
   output logic              bready,  // B ready
   output logic [ADDR_W-1:0] araddr,  // AR address
   output logic              arvalid, // AR valid
   input  wire logic         arready, // AR ready
   input  wire logic [31:0]  rdata,   // R data
   input  wire logic [1:0]   rresp,   // R response
   input  wire logic         rvalid,  // R valid
   output logic              rready   // R ready
);
   // Idle bus at time zero
   initial begin
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      {awaddr, araddr, wdata, wstrb} = '0;
   end
   // One word write
   task automatic wr(input logic [7:0] i, input logic [7:0] d,
                     output logic [1:0] r);
      bit a;
      bit w;
      a = 0;
      w = 0;
      @(posedge clock);
      awaddr  <= {i, 2'b00};
      wdata   <= {24'h0, d};
      wstrb   <= 4'h1;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      while (!(a && w)) begin
         @(posedge clock);
         if (!a && awready) begin
            a = 1;
            awvalid <= 1'b0;
            awaddr  <= ~awaddr;
         end
         if (!w && wready) begin
            w = 1;
            wvalid <= 1'b0;
            wdata  <= ~wdata;
         end
      end
      do @(posedge clock); while (!bvalid);
      r = bresp;
      bready <= 1'b0;
   endtask : wr
   // One word read
   task automatic rd(input logic [7:0] i, output logic [31:0] d,
                     output logic [1:0] r);
      @(posedge clock);
      araddr  <= {i, 2'b00};
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do @(posedge clock); while (!arready);
      arvalid <= 1'b0;
      araddr  <= ~araddr;
      while (!rvalid) @(posedge clock);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : rd
endmodule : wtc_host
`default_nettype wire

// >>> wtc_monitor.sv
// Checker for bus answers, wait timer and interrupt pin
`timescale 1ns/1ps
`default_nettype none
module wtc_monitor
   import wtc_pkg::*;
#(
   parameter int TICK_CYCLES = 4   // Clocks per wait tick
)(
   input wire logic        clock,     // Clock
   input wire logic        rst_b,     // Reset, low
   input wire logic        awvalid,   // AW valid
   input wire logic        awready,   // AW ready
   input wire logic        wvalid,    // W valid
   input wire logic        wready,    // W ready
   input wire logic        bvalid,    // B valid
   input wire logic        arvalid,   // AR valid
   input wire logic        arready,   // AR ready
   input wire logic [31:0] rdata,     // R data
   input wire logic [1:0]  rresp,     // R response
   input wire logic        rvalid,    // R valid
   input wire logic        als_done,  // Ambient done pulse
   input wire logic        prox_done, // Proximity done pulse
   input wire logic        wait_busy, // Wait running
   input wire logic        wait_done, // Wait end pulse
   input wire logic        irq        // Interrupt pin
);
   int bcnt_r;  // Busy cycles of the current wait
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);
   // Count busy cycles, cleared while idle
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) bcnt_r <= 0;
      else if (wait_busy) bcnt_r <= bcnt_r + 1;
      else bcnt_r <= 0;
   end
   a_read_answer:
      assert property (arvalid && arready |=> rvalid)
      else $error("Late read data");
   a_write_answer:
      assert property (awvalid && awready && wvalid && wready
                       |=> !bvalid ##1 bvalid)
      else $error("Late write response");
   a_rdata_upper:
      assert property (rvalid |-> rdata[31:8] == 24'h0)
      else $error("Upper read bits set");
   a_unmapped_zero:
      assert property (rvalid && rresp == RESP_SLVERR |-> rdata == 32'h0)
      else $error("Refused read returned data");
   a_busy_min:
      assert property ($rose(wait_busy) |-> wait_busy [*3])
      else $error("Short wait");
   a_done_ends_busy:
      assert property (wait_done |-> !wait_busy && $past(wait_busy))
      else $error("Done without busy");
   a_done_pulse:
      assert property (wait_done |=> !wait_done)
      else $error("Long done pulse");
   a_busy_units:
      assert property (wait_done |-> bcnt_r > 0
                       && bcnt_r % TICK_CYCLES == 0)
      else $error("Wait not whole ticks");
   a_irq_rise:
      assert property ($rose(irq) |-> $past(als_done, 3)
         || $past(prox_done, 3) || $past(wait_done, 2)
         || bvalid || $past(bvalid))
      else $error("Irq rose uncaused");
   a_irq_fall:
      assert property ($fell(irq) |-> bvalid || $past(bvalid))
      else $error("Irq fell uncaused");
   c_wait: cover property (wait_done);
   c_irq: cover property ($rose(irq));
   c_refuse: cover property (rvalid && rresp == RESP_SLVERR);
endmodule : wtc_monitor
bind wtc_top wtc_monitor #(.TICK_CYCLES(TICK_CYCLES)) mon_u (.*);
`default_nettype wire

// >>> testbench.sv
// Self-checking bench for the wait timer and threshold block
`timescale 1ns/1ps
`default_nettype none
module testbench import wtc_pkg::*;;
   localparam int T = 4;                   // Clocks per tick in sim
   logic clock, rst_b, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, irq, als_done, prox_done;
   logic wait_start, wait_busy, wait_done;  // Wait timer pins
   logic [ADDR_W-1:0] awaddr, araddr;       // Bus addresses
   logic [31:0]       wdata, rdata;         // Bus data
   logic [3:0]        wstrb;                // Write strobes
   logic [1:0]        bresp, rresp;         // Bus responses
   logic [15:0]       als_clear;            // Clear channel result
   logic [7:0]        prox_value, lat;      // Proximity, latch model
   logic [7:0]        sh [256];             // Register model
   int                cnt [2];              // Persistence counts
   int                errors, comparisons, cyc, dmy;
   wtc_top #(.TICK_CYCLES(T)) dut_u (.*);
   wtc_host host_u (.*);
   // Free running clock
   initial begin
      clock = 0;
      forever #2 clock = ~clock;
   end
   // Cut a hang short
   always @(posedge clock) begin
      cyc++;
      if (cyc == 60000) begin
         errors++;
         finish_test();
      end
   end
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         errors++;
         $display("CHECK FAILED %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   function automatic bit mapped(input logic [7:0] i);
      return i inside {8'h80, [8'h83:8'h88], 8'h8a, 8'h8c, 8'h8d,
                       8'h90, 8'h93};
   endfunction : mapped
   // Write, update model
   task automatic wreg(input logic [7:0] i, input logic [7:0] d);
      logic [1:0] r;
      host_u.wr(i, d, r);
      chk("bresp", 32'(mapped(i) ? RESP_OKAY : RESP_SLVERR), 32'(r));
      if (i == 8'h84 || i == 8'h86) lat = d;
      else if (i == 8'h85 || i == 8'h87) begin
         sh[i - 8'h01] = lat;
         sh[i] = d;
      end
      else if (i == 8'h93) sh[i] &= ~d;
      else if (mapped(i)) sh[i] = d;
   endtask : wreg
   task automatic rreg(input logic [7:0] i);
      logic [31:0] d;
      logic [1:0]  r;
      host_u.rd(i, d, r);
      chk("rresp", 32'(mapped(i) ? RESP_OKAY : RESP_SLVERR), 32'(r));
      chk("rdata", mapped(i) ? 32'(sh[i]) : 32'h0, d);
   endtask : rreg
   // One result, then status and pin
   task automatic meas(input bit p, input logic [15:0] v);
      logic [15:0] lo, hi;
      int ps, need;
      @(posedge clock);
      if (p) prox_value <= v[7:0];
      else als_clear <= v;
      prox_done <= p;
      als_done  <= !p;
      @(posedge clock);
      {prox_done, als_done} <= 2'b00;
      prox_value <= ~prox_value;
      als_clear  <= ~als_clear;
      repeat (3) @(posedge clock);
      lo = p ? 16'(sh[8'h88]) : {sh[8'h85], sh[8'h84]};
      hi = p ? 16'(sh[8'h8a]) : {sh[8'h87], sh[8'h86]};
      ps = p ? int'(sh[8'h8c][7:4]) : int'(sh[8'h8c][3:0]);
      need = (p || ps <= 3) ? ps : 5 * (ps - 3);
      cnt[p] = (v < lo || v > hi) ? cnt[p] + 1 : 0;
      if (ps == 0 || (cnt[p] > 0 && cnt[p] >= need)) sh[8'h93][p] = 1'b1;
      rreg(8'h93);
      chk("irq", 32'(|(sh[8'h93] & sh[8'h90])), 32'(irq));
   endtask : meas
   // Random out-of-range result
   function automatic logic [15:0] outv(input bit p);
      if ($urandom_range(1)) return p ? 16'($urandom_range(8'h3f))
                                      : 16'($urandom_range(16'h00ff));
      return p ? 16'(8'hc1 + $urandom_range(62))
               : 16'(16'h0201 + $urandom_range(16'hfdfe));
   endfunction : outv
   // Start a wait and count busy cycles
   task automatic wtest(input logic [7:0] n, input bit lng, input bit en);
      int c, e;
      wreg(8'h80, en ? 8'h08 : 8'h00);
      wreg(8'h83, n);
      wreg(8'h8d, lng ? 8'h84 : 8'h80);
      @(posedge clock);
      wait_start <= 1'b1;
      @(posedge clock);
      wait_start <= 1'b0;
      c = 0;
      e = en ? (int'(n) + 1) * T * (lng ? 12 : 1) : 0;
      repeat (e + 3) begin
         @(posedge clock);
         if (wait_busy === 1'b1) c++;
      end
      chk("busy_cycles", e, c);
      if (en) sh[8'h93][2] = 1'b1;
      rreg(8'h93);
   endtask : wtest
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : finish_test
   // Main sequence
   initial begin
      {rst_b, als_done, prox_done, wait_start} = 4'h0;
      {als_clear, prox_value, lat} = '0;
      {errors, comparisons, cyc, cnt[0], cnt[1]} = '0;
      foreach (sh[i]) sh[i] = 8'h00;
      sh[8'h8d] = 8'h80;
      repeat (6) @(posedge clock);
      rst_b <= 1'b1;
      dmy = $urandom(32'h495d);
      for (int i = 8'h80; i < 8'h94; i++) rreg(8'(i));
      wreg(8'h89, 8'h5a);
      rreg(8'h89);
      $display("test reset_map done");
      wreg(8'h84, 8'h34);
      rreg(8'h84);
      wreg(8'h85, 8'h12);
      rreg(8'h84);
      wreg(8'h86, 8'h77);
      wreg(8'h85, 8'h01);
      rreg(8'h84);
      rreg(8'h86);
      $display("test latch done");
      foreach (sh[i]) if (i inside {[8'h84:8'h8a]}) wreg(8'(i), 8'h00);
      wreg(8'h85, 8'h01);
      wreg(8'h87, 8'h02);
      wreg(8'h88, 8'h40);
      wreg(8'h8a, 8'hc0);
      wreg(8'h90, 8'h07);
      for (int p = 0; p < 2; p++) begin
         for (int v = 0; v < 16; v++) begin
            wreg(8'h8c, p ? 8'(v << 4) : 8'(v));
            wreg(8'h93, 8'h07);
            meas(p[0], p ? 16'h00c0 : 16'h0100);
            wreg(8'h93, 8'h07);
            for (int k = 0; k < 61 && !sh[8'h93][p]; k++)
               meas(p[0], outv(p[0]));
         end
      end
      wreg(8'h90, 8'h00);
      @(posedge clock);
      chk("irq_masked", 32'h0, 32'(irq));
      $display("test thresholds done");
      wtest(8'h00, 1'b0, 1'b1);
      wtest(8'($urandom_range(31)), 1'b0, 1'b1);
      wtest(8'h01, 1'b1, 1'b1);
      wtest(8'h03, 1'b0, 1'b0);
      $display("test wait done");
      finish_test();
   end
endmodule : testbench
`default_nettype wire
